// file: hw/tmr2_params.svh
// offsets, field positions and reset values of the timer 2 register block
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH

`define TMR2_OFS_T0_LOW    8'h8a
`define TMR2_OFS_T1_LOW    8'h8b
`define TMR2_OFS_T0_HIGH   8'h8c
`define TMR2_OFS_T1_HIGH   8'h8d
`define TMR2_OFS_CTRL      8'hc8
`define TMR2_OFS_RLD_LOW   8'hca
`define TMR2_OFS_RLD_HIGH  8'hcb
`define TMR2_OFS_CNT_LOW   8'hcc
`define TMR2_OFS_CNT_HIGH  8'hcd
`define TMR2_OFS_IRQ_STAT  8'he8
`define TMR2_OFS_IRQ_MASK  8'he9

`define TMR2_T01_COUNT     4
`define TMR2_T01_IDX_FLIP  2'h2

`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXT       6
`define TMR2_BIT_RCLK      5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT      4
`define TMR2_BIT_EXEN      3
`define TMR2_BIT_RUN       2
`define TMR2_BIT_CTS       1
`define TMR2_BIT_CAP       0

`define TMR2_IRQ_OVF       0
`define TMR2_IRQ_EXT       1
`define TMR2_IRQ_WIDTH     2

`define TMR2_RST_BYTE      8'h00
`define TMR2_RST_CNT       16'h0000
`define TMR2_RST_IRQ       2'h0
`define TMR2_CNT_MAX       16'hffff
`define TMR2_CNT_STEP      16'h0001

`endif

// file: hw/tmr2_pkg.sv
// types shared by the timer 2 register block
package tmr2_pkg;
  typedef logic [7:0]  tmr2_byte_t;
  typedef logic [15:0] tmr2_word_t;
  typedef enum logic [1:0] {
    TMR2_MODE_OFF  = 2'b00,
    TMR2_MODE_AUTO = 2'b01,
    TMR2_MODE_CAPT = 2'b11,
    TMR2_MODE_BAUD = 2'b10
  } tmr2_mode_e;
endpackage

// file: hw/tmr2_top.sv
// timer 2 control, timer 0/1/2 data bytes, reload/capture pair and interrupt logic
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "tmr2_params.svh"

module tmr2_top (
  input  wire logic              i_clk,          // core clock, 200 MHz
  input  wire logic              i_nrst,         // async reset, active low
  input  wire logic              i_ce,           // clock enable, freezes all state
  input  wire tmr2_pkg::tmr2_byte_t i_addr,      // register address
  input  wire tmr2_pkg::tmr2_byte_t i_wdata,     // write data
  input  wire logic              i_wr,           // write strobe
  input  wire logic              i_rd,           // read strobe
  output tmr2_pkg::tmr2_byte_t   o_rdata,        // read data, cycle after strobe
  input  wire logic              i_count_pin,    // external count input
  input  wire logic              i_trigger_pin,  // external trigger input
  input  wire logic              i_t1_ovf,       // timer 1 overflow pulse
  output logic                   o_rx_clk_tick,  // serial receive clock pulse
  output logic                   o_tx_clk_tick,  // serial transmit clock pulse
  output logic                   o_t2_ovf_pulse, // timer 2 overflow pulse
  output logic                   o_irq           // level interrupt
);
  import tmr2_pkg::*;

  tmr2_byte_t ctrl_q;
  tmr2_byte_t ctrl_d;
  tmr2_word_t cnt_q;
  tmr2_word_t cnt_d;
  tmr2_word_t cnt_hw;
  tmr2_word_t rld_q;
  tmr2_word_t rld_d;
  tmr2_byte_t t01_q [`TMR2_T01_COUNT];
  tmr2_byte_t rdata_q;
  tmr2_byte_t rd_mux;
  logic [`TMR2_IRQ_WIDTH-1:0] stat_q;
  logic [`TMR2_IRQ_WIDTH-1:0] stat_d;
  logic [`TMR2_IRQ_WIDTH-1:0] stat_set;
  logic [`TMR2_IRQ_WIDTH-1:0] stat_clr;
  logic [`TMR2_IRQ_WIDTH-1:0] mask_q;
  logic [2:0] cnt_sync_q;
  logic [2:0] trg_sync_q;
  logic       rx_tick_q;
  logic       tx_tick_q;
  logic       ovf_pulse_q;
  tmr2_mode_e mode;
  logic       reload_on_ovf;
  logic       trig_reload;
  logic       trig_capture;

  // field aliases
  wire run  = ctrl_q[`TMR2_BIT_RUN];
  wire cts  = ctrl_q[`TMR2_BIT_CTS];
  wire capm = ctrl_q[`TMR2_BIT_CAP];
  wire exen = ctrl_q[`TMR2_BIT_EXEN];
  wire rclk = ctrl_q[`TMR2_BIT_RCLK];
  wire transmit_clock_select = ctrl_q[`TMR2_BIT_TRANSMIT_CLOCK_SELECT];
  wire baud = rclk | transmit_clock_select;

  // address decode
  wire hit_ctrl  = (i_addr == `TMR2_OFS_CTRL);
  wire hit_rldl  = (i_addr == `TMR2_OFS_RLD_LOW);
  wire hit_rldh  = (i_addr == `TMR2_OFS_RLD_HIGH);
  wire hit_cntl  = (i_addr == `TMR2_OFS_CNT_LOW);
  wire hit_cnth  = (i_addr == `TMR2_OFS_CNT_HIGH);
  wire hit_stat  = (i_addr == `TMR2_OFS_IRQ_STAT);
  wire hit_mask  = (i_addr == `TMR2_OFS_IRQ_MASK);
  wire hit_t01   = (i_addr >= `TMR2_OFS_T0_LOW) && (i_addr <= `TMR2_OFS_T1_HIGH);
  wire [1:0] t01_idx = i_addr[1:0] ^ `TMR2_T01_IDX_FLIP;
  wire wr_ctrl = i_wr & hit_ctrl;
  wire wr_rldl = i_wr & hit_rldl;
  wire wr_rldh = i_wr & hit_rldh;
  wire wr_cntl = i_wr & hit_cntl;
  wire wr_cnth = i_wr & hit_cnth;
  wire wr_stat = i_wr & hit_stat;
  wire wr_mask = i_wr & hit_mask;

  // pin edges from the synchronised samples only
  wire cnt_fall = cnt_sync_q[2] & ~cnt_sync_q[1];
  wire trg_fall = trg_sync_q[2] & ~trg_sync_q[1];

  // count enable and overflow
  wire tick = run & (cts ? cnt_fall : 1'b1);
  wire ovf  = tick & (cnt_q == `TMR2_CNT_MAX);
  wire trig = exen & trg_fall & ~baud;

  // operating mode
  always_comb begin
    if (!run) begin
      mode = TMR2_MODE_OFF;
    end else if (baud) begin
      mode = TMR2_MODE_BAUD;
    end else if (capm) begin
      mode = TMR2_MODE_CAPT;
    end else begin
      mode = TMR2_MODE_AUTO;
    end
  end

  always_comb begin
    reload_on_ovf = 1'b0;
    trig_reload   = 1'b0;
    trig_capture  = 1'b0;
    case (mode)
      TMR2_MODE_AUTO: begin
        reload_on_ovf = 1'b1;
        trig_reload   = trig;
      end
      TMR2_MODE_CAPT: begin
        trig_capture  = trig;
      end
      TMR2_MODE_BAUD: begin
        reload_on_ovf = 1'b1;
      end
      TMR2_MODE_OFF: begin
        reload_on_ovf = 1'b0;
      end
      default: begin
        reload_on_ovf = 1'b0;
      end
    endcase
  end

  wire do_reload = (ovf & reload_on_ovf) | trig_reload;

  // count next value; a software byte write wins over the hardware update
  assign cnt_hw = do_reload ? rld_q : (tick ? cnt_q + `TMR2_CNT_STEP : cnt_q);
  assign cnt_d  = {wr_cnth ? i_wdata : cnt_hw[15:8],
                   wr_cntl ? i_wdata : cnt_hw[7:0]};

  // capture wins over a software write to the reload pair
  assign rld_d = trig_capture ? cnt_q :
                 {wr_rldh ? i_wdata : rld_q[15:8],
                  wr_rldl ? i_wdata : rld_q[7:0]};

  // control register; hardware set wins over software clear
  wire ovf_set = ovf & ~baud;
  wire ext_set = trig_reload | trig_capture;
  wire [5:0] ctrl_low = wr_ctrl ? i_wdata[5:0] : ctrl_q[5:0];
  wire ovf_keep = wr_ctrl ? i_wdata[`TMR2_BIT_OVF] : ctrl_q[`TMR2_BIT_OVF];
  wire ext_keep = wr_ctrl ? i_wdata[`TMR2_BIT_EXT] : ctrl_q[`TMR2_BIT_EXT];
  assign ctrl_d = {ovf_set | ovf_keep, ext_set | ext_keep, ctrl_low};

  // interrupt status, write one to clear, set wins
  assign stat_set = {ext_set, ovf_set};
  assign stat_clr = wr_stat ? i_wdata[`TMR2_IRQ_WIDTH-1:0] : `TMR2_RST_IRQ;
  assign stat_d   = stat_set | (stat_q & ~stat_clr);

  // serial clock source selection
  wire rx_src = rclk ? ovf : i_t1_ovf;
  wire tx_src = transmit_clock_select ? ovf : i_t1_ovf;

  // read selection
  assign rd_mux = ({8{hit_ctrl}} & ctrl_q)
                | ({8{hit_rldl}} & rld_q[7:0])
                | ({8{hit_rldh}} & rld_q[15:8])
                | ({8{hit_cntl}} & cnt_q[7:0])
                | ({8{hit_cnth}} & cnt_q[15:8])
                | ({8{hit_stat}} & {6'h00, stat_q})
                | ({8{hit_mask}} & {6'h00, mask_q})
                | ({8{hit_t01}}  & t01_q[t01_idx]);

  // timer 0 and timer 1 data bytes
  genvar gi;
  generate
    for (gi = 0; gi < `TMR2_T01_COUNT; gi = gi + 1) begin : g_t01
      wire wr_me = i_wr & hit_t01 & (t01_idx == 2'(gi));
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          t01_q[gi] <= `TMR2_RST_BYTE;
        end else if (i_ce && wr_me) begin
          t01_q[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  // pin synchronisers and edge history
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_sync_q <= 3'h0;
      trg_sync_q <= 3'h0;
    end else if (i_ce) begin
      cnt_sync_q <= {cnt_sync_q[1:0], i_count_pin};
      trg_sync_q <= {trg_sync_q[1:0], i_trigger_pin};
    end
  end

  // timer state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= `TMR2_RST_BYTE;
      cnt_q  <= `TMR2_RST_CNT;
      rld_q  <= `TMR2_RST_CNT;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      cnt_q  <= cnt_d;
      rld_q  <= rld_d;
    end
  end

  // interrupt registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_q <= `TMR2_RST_IRQ;
      mask_q <= `TMR2_RST_IRQ;
    end else if (i_ce) begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= i_wdata[`TMR2_IRQ_WIDTH-1:0];
      end
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q     <= `TMR2_RST_BYTE;
      rx_tick_q   <= 1'b0;
      tx_tick_q   <= 1'b0;
      ovf_pulse_q <= 1'b0;
    end else if (i_ce) begin
      rdata_q     <= i_rd ? rd_mux : `TMR2_RST_BYTE;
      rx_tick_q   <= rx_src;
      tx_tick_q   <= tx_src;
      ovf_pulse_q <= ovf;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_rx_clk_tick  = rx_tick_q;
  assign o_tx_clk_tick  = tx_tick_q;
  assign o_t2_ovf_pulse = ovf_pulse_q;
  assign o_irq          = |(stat_q & mask_q);

endmodule

// file: bench/tmr2_chk.sv
// port assertions of the timer 2 block
`timescale 1ns/10ps
module tmr2_chk (
  input wire logic       i_clk,          // clock
  input wire logic       i_nrst,         // reset, active low
  input wire logic       i_ce,           // clock enable
  input wire logic [7:0] i_addr,         // address
  input wire logic [7:0] i_wdata,        // write data
  input wire logic       i_wr,           // write strobe
  input wire logic       i_rd,           // read strobe
  input wire logic [7:0] o_rdata,        // read data
  input wire logic       i_t1_ovf,       // timer 1 overflow
  input wire logic       o_rx_clk_tick,  // rx tick
  input wire logic       o_tx_clk_tick,  // tx tick
  input wire logic       o_t2_ovf_pulse, // overflow pulse
  input wire logic       o_irq           // interrupt
);
  logic [5:0] ctl_q;
  logic [1:0] msk_q;
  logic [2:0] ce_q;
  // shadow of software-only control bits and mask; frozen writes ignored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= 6'h00;
      msk_q <= 2'h0;
    end else if (i_ce && i_wr && i_addr == 8'hc8) begin
      ctl_q <= i_wdata[5:0];
    end else if (i_ce && i_wr && i_addr == 8'he9) begin
      msk_q <= i_wdata[1:0];
    end
  end
  // recent clock enable history; checks pause around frozen cycles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ce_q <= 3'h7;
    end else begin
      ce_q <= {ce_q[1:0], i_ce};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst || !i_ce || ce_q != 3'h7);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_ctl; $past(i_rd) && $past(i_addr) == 8'hc8 |-> o_rdata[5:0] == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control bits wrong");
  property p_t0_rw; i_wr && i_addr == 8'h8a ##2 i_rd && i_addr == 8'h8a && !$past(i_wr)
    |=> o_rdata == $past(i_wdata, 3); endproperty
  a_t0_rw: assert property (p_t0_rw) else $error("timer 0 byte lost");
  property p_t1_rw; i_wr && i_addr == 8'h8d ##2 i_rd && i_addr == 8'h8d && !$past(i_wr)
    |=> o_rdata == $past(i_wdata, 3); endproperty
  a_t1_rw: assert property (p_t1_rw) else $error("timer 1 byte lost");
  property p_rx_sel; o_rx_clk_tick == ($past(ctl_q[5]) ? o_t2_ovf_pulse : $past(i_t1_ovf));
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx tick source wrong");
  property p_tx_sel; o_tx_clk_tick == ($past(ctl_q[4]) ? o_t2_ovf_pulse : $past(i_t1_ovf));
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("tx tick source wrong");
  property p_stop; !$past(ctl_q[2]) && !$past(ctl_q[2], 2) && !$past(ctl_q[2], 3)
    |-> !o_t2_ovf_pulse; endproperty
  a_stop: assert property (p_stop) else $error("overflow while stopped");
  property p_irq_mask; msk_q == 2'h0 |-> !o_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule
bind tmr2_top tmr2_chk u_chk (.*);

// file: bench/tmr2_pins.sv
// count and trigger pin drivers, idle high
`timescale 1ns/10ps
module tmr2_pins (
  input  wire logic i_clk,    // clock
  input  wire logic i_cnt_go, // start low pulse on count pin
  input  wire logic i_trg_go, // start low pulse on trigger pin
  output logic      o_cnt,    // count pin
  output logic      o_trg     // trigger pin
);
  logic [2:0] cnt_q = 3'h0;
  logic [2:0] trg_q = 3'h0;
  // each pulse holds the pin low four cycles
  always_ff @(posedge i_clk) begin
    cnt_q <= i_cnt_go ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
    trg_q <= i_trg_go ? 3'h4 : trg_q - {2'h0, trg_q != 3'h0};
  end
  assign o_cnt = cnt_q == 3'h0;
  assign o_trg = trg_q == 3'h0;
endmodule

// file: bench/tb.sv
// self-checking bench of the timer 2 block
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] rst_addr [12] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca, 8'hcb,
                                           8'hcc, 8'hcd, 8'he8, 8'he9, 8'h00};
  localparam logic [7:0] rw_addr [6] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hca, 8'hcb};
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_t1_ovf = 1'b0;
  logic        i_ce = 1'b1;
  logic        cnt_go = 1'b0;
  logic        trg_go = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic [7:0]  rdata;
  logic [15:0] lf = 16'hfe2e;
  logic        cnt_pin, trg_pin, rx, tx, ovf, irq;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          mdl [int];
  always #2.5 i_clk = ~i_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    lf <= lfsr(lf);
    i_t1_ovf <= i_nrst & lf[0] & lf[5];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  tmr2_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_count_pin(cnt_pin),
    .i_trigger_pin(trg_pin), .i_t1_ovf(i_t1_ovf), .o_rx_clk_tick(rx), .o_tx_clk_tick(tx),
    .o_t2_ovf_pulse(ovf), .o_irq(irq));
  tmr2_pins u_pins (.i_clk(i_clk), .i_cnt_go(cnt_go), .i_trg_go(trg_go), .o_cnt(cnt_pin),
    .o_trg(trg_pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // list of {address, data} writes
  task automatic wrs(input logic [15:0] q [$]);
    foreach (q[i]) wr(q[i][15:8], q[i][7:0]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // falling edge on trigger (1) or count (0) pin
  task automatic pulse(input bit trg);
    @(posedge i_clk);
    trg_go <= trg;
    cnt_go <= !trg;
    @(posedge i_clk);
    trg_go <= 1'b0;
    cnt_go <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rst_addr[i]) rd(rst_addr[i], 8'h00);
    foreach (rw_addr[i]) begin
      mdl[rw_addr[i]] = lf[7:0];
      wr(rw_addr[i], lf[7:0]);
      rd(rw_addr[i], 8'(mdl[rw_addr[i]]));
    end
    wrs({16'hccfe, 16'hcdff, 16'hca34, 16'hcb12, 16'he903, 16'hc804});
    repeat (6) @(posedge i_clk);
    rd(8'hcd, 8'h12);
    rd(8'hc8, 8'h84);
    chk({7'h0, irq}, 8'h01);
    wr(8'he8, 8'h03);
    #1 chk({7'h0, irq}, 8'h00);
    wrs({16'hc800, 16'hcc55});
    rd(8'hc8, 8'h00);
    repeat (20) @(posedge i_clk);
    rd(8'hcc, 8'h55);
    wrs({16'hccf0, 16'hcdff, 16'hcaf0, 16'hcbff, 16'hc83c});
    repeat (40) @(posedge i_clk);
    pulse(1'b1);
    rd(8'hc8, 8'h3c);
    rd(8'hcd, 8'hff);
    rd(8'he8, 8'h00);
    wrs({16'hc800, 16'hcc00, 16'hcd56, 16'hc80d});
    pulse(1'b1);
    rd(8'hc8, 8'h4d);
    rd(8'hcb, 8'h56);
    chk({7'h0, irq}, 8'h01);
    wrs({16'hc800, 16'he803, 16'hcc00, 16'hcd77, 16'hca00, 16'hcb21, 16'hc80c});
    pulse(1'b1);
    rd(8'hcd, 8'h21);
    rd(8'hc8, 8'h4c);
    wrs({16'hc804, 16'hcc00, 16'hcd77});
    pulse(1'b1);
    rd(8'hcd, 8'h77);
    wrs({16'he900, 16'hc800, 16'hcc00, 16'hcd00, 16'hc806});
    repeat (3) pulse(1'b0);
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'h03);
    // a write while the clock enable is low must not land
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(8'h8a, 8'ha5);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd(8'h8a, 8'(mdl[8'h8a]));
    stop_test();
  end
endmodule
